// ==== ofr_top.sv ====
// Purpose: fault limits, status and response for one output rail
// Assumes: samples and command strobes arrive on clk
// Notes: strap voltage is a pin and is synchronised
`timescale 1ns/100ps
`default_nettype none
module ofr_top
    import ofr_pkg::*;
#(
    parameter int          UV_UNIT_US = 1000,
    parameter int          OC_UNIT_US = 1000,
    parameter int          UC_UNIT_US = 1000,
    parameter int          OT_UNIT_US = 1000,
    parameter logic [7:0]  IC_RSP     = 8'h80
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // command port
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    // rail control
    input  wire logic [15:0] strap_vout,
    input  wire logic        enable_req,
    input  wire logic        ramping,
    output logic             out_en,
    // measurements
    input  wire logic [15:0] vout_meas,
    input  wire logic        isense_valid,
    input  wire logic        blank_done,
    input  wire logic [15:0] i_peak,
    input  wire logic [15:0] i_valley,
    input  wire logic [15:0] temp_meas,
    // status
    output logic             stat_uv,
    output logic             stat_oc,
    output logic             stat_uc,
    output logic             stat_ot,
    output logic             stat_otw,
    output logic             stat_temp,
    output logic             alert_n
);
    localparam int UV_CYC = UV_UNIT_US * CLK_MHZ;
    localparam int OC_CYC = OC_UNIT_US * CLK_MHZ;
    localparam int UC_CYC = UC_UNIT_US * CLK_MHZ;
    localparam int OT_CYC = OT_UNIT_US * CLK_MHZ;

    // reset release
    logic        rs1_r, rst_n;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rs1_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_r <= 1'b1;
            rst_n <= rs1_r;
        end
    end

    // strap synchroniser and one-shot capture
    logic [15:0] strap1_r, strap2_r;
    logic [1:0]  boot_r;
    logic        strap_ld;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            strap1_r <= 16'h0000;
            strap2_r <= 16'h0000;
        end else begin
            strap1_r <= strap_vout;
            strap2_r <= strap1_r;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) boot_r <= 2'h0;
        else if (boot_r != 2'h3) boot_r <= boot_r + 2'h1;
    end
    // wait until the second stage holds a real pin sample
    assign strap_ld = (boot_r == 2'h2);

    function automatic logic [15:0] uv_default(input logic [15:0] v);
        logic [20:0] p;
        p = 21'(v) * 21'(UV_NUM);
        return 16'(p / 21'(UV_DEN));
    endfunction

    function automatic logic over(input logic [15:0] a, input logic [15:0] b);
        return $signed(a) > $signed(b);
    endfunction

    // writable words
    logic [15:0] uv_lim_r, oc_lim_r, uc_lim_r, ot_lim_r, otw_lim_r, vcfg_r;
    logic [7:0]  uv_rsp_r, ot_rsp_r;
    logic        wr, rd, clr;
    assign wr  = cmd_valid & cmd_write;
    assign rd  = cmd_valid & ~cmd_write;
    assign clr = wr & (cmd_code == CMD_CLR);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) uv_lim_r <= 16'h0000;
        else if (strap_ld) uv_lim_r <= uv_default(strap2_r);
        else if (wr && cmd_code == CMD_UV_LIM) uv_lim_r <= cmd_wdata;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uv_rsp_r  <= RST_RSP;
            ot_rsp_r  <= RST_RSP;
            oc_lim_r  <= RST_OC;
            uc_lim_r  <= RST_UC;
            ot_lim_r  <= RST_OT;
            otw_lim_r <= RST_OTW;
            vcfg_r    <= RST_VCFG;
        end else if (wr) begin
            case (cmd_code)
                CMD_UV_RSP:  uv_rsp_r  <= cmd_wdata[7:0];
                CMD_OT_RSP:  ot_rsp_r  <= cmd_wdata[7:0];
                CMD_OC_LIM:  oc_lim_r  <= cmd_wdata;
                CMD_UC_LIM:  uc_lim_r  <= cmd_wdata;
                CMD_OT_LIM:  ot_lim_r  <= cmd_wdata;
                CMD_OTW_LIM: otw_lim_r <= cmd_wdata;
                CMD_VCFG:    vcfg_r    <= cmd_wdata;
                default:     vcfg_r    <= vcfg_r;
            endcase
        end
    end

    // undervoltage, blind while ramping or off
    logic uv_cond;
    assign uv_cond = enable_req & ~ramping & over(uv_lim_r, vout_meas);

    // consecutive-sample current filters
    logic [3:0] need;
    logic [3:0] oc_run_r, uc_run_r;
    logic       oc_cond, uc_cond, isamp;
    assign need  = vcfg_r[VCFG_CNT_HI:0];
    assign isamp = isense_valid & blank_done;

    function automatic logic [3:0] run_step(input logic [3:0] r,
                                            input logic hit);
        if (!hit) return 4'h0;
        return (r == 4'hF) ? r : r + 4'h1;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oc_run_r <= 4'h0;
            uc_run_r <= 4'h0;
        end else if (isamp) begin
            oc_run_r <= run_step(oc_run_r, over(i_peak, oc_lim_r));
            uc_run_r <= run_step(uc_run_r, over(uc_lim_r, i_valley));
        end
    end
    // a count of zero is treated as one so a fault is still possible
    assign oc_cond = (oc_run_r != 4'h0) && (oc_run_r >= need);
    assign uc_cond = (uc_run_r != 4'h0) && (uc_run_r >= need);

    // overtemperature with warning-limit hysteresis
    logic ot_cond_r, otw_cond;
    assign otw_cond = over(temp_meas, otw_lim_r);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ot_cond_r <= 1'b0;
        else if (over(temp_meas, ot_lim_r)) ot_cond_r <= 1'b1;
        else if (over(otw_lim_r, temp_meas)) ot_cond_r <= 1'b0;
    end

    // sticky status: a new fault beats a same-cycle clear
    logic [5:0] stat_r, stat_set;
    assign stat_set = {otw_cond, otw_cond, ot_cond_r, uc_cond, oc_cond, uv_cond};
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) stat_r <= 6'h00;
        else stat_r <= stat_set | (clr ? 6'h00 : stat_r);
    end
    assign stat_uv   = stat_r[ST_UV];
    assign stat_oc   = stat_r[ST_OC];
    assign stat_uc   = stat_r[ST_UC];
    assign stat_ot   = stat_r[ST_OT];
    assign stat_otw  = stat_r[ST_OTW];
    assign stat_temp = stat_r[ST_TEMP];
    assign alert_n   = ~|stat_r;

    // per-fault response sequencers
    logic [NFLT-1:0] flt, off;
    logic [7:0]      rsp [NFLT];
    assign flt = {ot_cond_r, uc_cond, oc_cond, uv_cond};
    assign rsp[0] = uv_rsp_r;
    assign rsp[1] = IC_RSP;
    assign rsp[2] = IC_RSP;
    assign rsp[3] = ot_rsp_r;

    ofr_seq #(.UNIT_CYC(UV_CYC)) u_seq_uv (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (enable_req),
        .clr   (clr),
        .fault (flt[0]),
        .rsp   (rsp[0]),
        .off   (off[0])
    );
    ofr_seq #(.UNIT_CYC(OC_CYC)) u_seq_oc (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (enable_req),
        .clr   (clr),
        .fault (flt[1]),
        .rsp   (rsp[1]),
        .off   (off[1])
    );
    ofr_seq #(.UNIT_CYC(UC_CYC)) u_seq_uc (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (enable_req),
        .clr   (clr),
        .fault (flt[2]),
        .rsp   (rsp[2]),
        .off   (off[2])
    );
    ofr_seq #(.UNIT_CYC(OT_CYC)) u_seq_ot (
        .clk   (clk),
        .rst_n (rst_n),
        .en    (enable_req),
        .clr   (clr),
        .fault (flt[3]),
        .rsp   (rsp[3]),
        .off   (off[3])
    );

    // any sequencer holding off wins, so one fault stops another's retries
    assign out_en = enable_req & ~|off;

    // read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) cmd_rdata <= 16'h0000;
        else if (rd) begin
            case (cmd_code)
                CMD_UV_LIM:  cmd_rdata <= uv_lim_r;
                CMD_UV_RSP:  cmd_rdata <= {8'h00, uv_rsp_r};
                CMD_OC_LIM:  cmd_rdata <= oc_lim_r;
                CMD_UC_LIM:  cmd_rdata <= uc_lim_r;
                CMD_OT_LIM:  cmd_rdata <= ot_lim_r;
                CMD_OT_RSP:  cmd_rdata <= {8'h00, ot_rsp_r};
                CMD_OTW_LIM: cmd_rdata <= otw_lim_r;
                CMD_VCFG:    cmd_rdata <= vcfg_r;
                CMD_STAT:    cmd_rdata <= {6'h00, off, stat_r};
                default:     cmd_rdata <= 16'h0000;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_uv_mask: assert property (
        ramping || !enable_req |-> !uv_cond)
        else $error("undervoltage seen while masked");
    chk_uv_default: assert property (
        strap_ld |=> uv_lim_r == uv_default($past(strap2_r)))
        else $error("undervoltage default wrong");
    chk_stat_sticky: assert property (
        stat_r[ST_UV] && !clr |=> stat_r[ST_UV])
        else $error("fault status lost without clear");
    chk_stat_set: assert property (
        oc_cond && clr |=> stat_oc)
        else $error("fault lost to same-cycle clear");
    chk_blank: assert property (
        !isamp |=> oc_run_r == $past(oc_run_r))
        else $error("current run moved without valid sample");
    chk_oc_break: assert property (
        isamp && !over(i_peak, oc_lim_r) |=> !oc_cond)
        else $error("overcurrent run not broken by passing sample");
    chk_ot_hyst: assert property (
        ot_cond_r && !over(otw_lim_r, temp_meas) |=> ot_cond_r)
        else $error("overtemperature cleared above warning");
    chk_warn_alert: assert property (
        otw_cond |=> stat_temp && stat_otw && !alert_n)
        else $error("warning not reported");
endmodule // ofr_top
`default_nettype wire

// ==== ofr_pkg.sv ====
// Purpose: constants for output fault response control
// Assumes: command codes address the limit and response words
// Notes: limit words compared as raw signed values
package ofr_pkg;
    localparam logic [7:0]  CMD_CLR     = 8'h03;
    localparam logic [7:0]  CMD_UV_LIM  = 8'h44;
    localparam logic [7:0]  CMD_UV_RSP  = 8'h45;
    localparam logic [7:0]  CMD_OC_LIM  = 8'h46;
    localparam logic [7:0]  CMD_UC_LIM  = 8'h4B;
    localparam logic [7:0]  CMD_OT_LIM  = 8'h4F;
    localparam logic [7:0]  CMD_OT_RSP  = 8'h50;
    localparam logic [7:0]  CMD_OTW_LIM = 8'h51;
    localparam logic [7:0]  CMD_VCFG    = 8'hD0;
    localparam logic [7:0]  CMD_STAT    = 8'hE0;
    localparam logic [7:0]  RST_RSP     = 8'h80;
    localparam logic [15:0] RST_OC      = 16'hE200;
    localparam logic [15:0] RST_UC      = 16'hE600;
    localparam logic [15:0] RST_OT      = 16'hEBE8;
    localparam logic [15:0] RST_OTW     = 16'hEB70;
    localparam logic [15:0] RST_VCFG    = 16'h0001;
    localparam int          UV_NUM      = 17;
    localparam int          UV_DEN      = 20;
    localparam int          VCFG_CNT_HI = 3;
    localparam int          CLK_MHZ     = 20;
    localparam int ST_UV = 0, ST_OC = 1, ST_UC = 2;
    localparam int ST_OT = 3, ST_OTW = 4, ST_TEMP = 5;
    localparam int NFLT = 4;
    typedef enum logic [1:0] {
        RSP_IGNORE = 2'b00, RSP_DELAY = 2'b01,
        RSP_OFF    = 2'b10, RSP_HOLD  = 2'b11
    } ofr_rsp_e;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000, S_DELAY = 3'b001, S_OFF  = 3'b011,
        S_WAIT  = 3'b010, S_LATCH = 3'b110, S_HOLD = 3'b100
    } ofr_st_e;
endpackage

// ==== ofr_seq.sv ====
// Purpose: one fault's delay, disable and retry sequencer
// Assumes: fault is a level on the clk domain
// Notes: prescaler runs free, so the first unit may be short
`timescale 1ns/100ps
`default_nettype none
module ofr_seq
    import ofr_pkg::*;
#(
    parameter int UNIT_CYC = 20000
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       en,
    input  wire logic       clr,
    input  wire logic       fault,
    input  wire logic [7:0] rsp,
    // result
    output logic            off
);
    localparam int PW = $clog2(UNIT_CYC + 1);
    localparam logic [PW-1:0] PTOP = PW'(UNIT_CYC - 1);
    ofr_st_e       st_r, st_nxt;
    logic [PW-1:0] pre_r;
    logic [2:0]    tmr_r;
    logic [2:0]    try_r;
    logic          armed_r;
    logic          tick, expire, stop;
    ofr_rsp_e      code;
    assign code   = ofr_rsp_e'(rsp[7:6]);
    assign stop   = clr | ~en;
    assign tick   = (pre_r == '0);
    assign expire = tick & (tmr_r == 3'h0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) pre_r <= PTOP;
        else pre_r <= tick ? PTOP : pre_r - 1'b1;
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            S_IDLE: begin
                if (!stop && fault) begin
                    case (code)
                        RSP_DELAY: st_nxt = S_DELAY;
                        RSP_OFF:   st_nxt = S_OFF;
                        RSP_HOLD:  st_nxt = S_HOLD;
                        default:   st_nxt = S_IDLE;
                    endcase
                end
            end
            S_DELAY: begin
                if (stop || !fault) st_nxt = S_IDLE;
                else if (expire) st_nxt = S_OFF;
            end
            S_OFF: begin
                if (stop) st_nxt = S_IDLE;
                else if (try_r == 3'h0) st_nxt = S_LATCH;
                else st_nxt = S_WAIT;
            end
            S_WAIT: begin
                if (stop || expire) st_nxt = S_IDLE;
            end
            S_HOLD:  if (stop || !fault) st_nxt = S_IDLE;
            S_LATCH: if (stop) st_nxt = S_IDLE;
            default: st_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) st_r <= S_IDLE;
        else st_r <= st_nxt;
    end

    // delay count reloads on each entry to a timed state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) tmr_r <= 3'h0;
        else if ((st_nxt == S_DELAY || st_nxt == S_WAIT) && st_nxt != st_r)
            tmr_r <= rsp[2:0];
        else if (tick && tmr_r != 3'h0) tmr_r <= tmr_r - 3'h1;
    end

    // retries survive restarts until the fault episode is stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            try_r   <= 3'h0;
            armed_r <= 1'b0;
        end else if (stop) begin
            armed_r <= 1'b0;
        end else if (st_r == S_IDLE && fault && !armed_r) begin
            try_r   <= rsp[5:3];
        end else if (st_r == S_WAIT && expire) begin
            armed_r <= 1'b1;
            if (rsp[5:3] != 3'h7) try_r <= try_r - 3'h1;
        end
    end

    assign off = (st_r == S_OFF) | (st_r == S_WAIT) |
                 (st_r == S_HOLD) | (st_r == S_LATCH);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    chk_ignore_code: assert property (
        st_r == S_IDLE && code == RSP_IGNORE |=> st_r == S_IDLE && !off)
        else $error("ignored fault changed output");
    chk_off_now: assert property (
        st_r == S_IDLE && !stop && fault && code == RSP_OFF |=> off)
        else $error("code 10 did not disable at once");
    chk_hold_fault: assert property (
        st_r == S_HOLD && !stop && fault |=> off ##0 st_r == S_HOLD)
        else $error("hold released with fault present");
    chk_hold_free: assert property (
        st_r == S_HOLD && !fault |=> !off)
        else $error("hold did not release");
    chk_no_retry: assert property (
        st_r == S_LATCH && !stop |=> st_r == S_LATCH && off)
        else $error("latched output restarted");
    chk_delay_on: assert property (
        st_r == S_DELAY && fault && !stop && !expire |=> st_r == S_DELAY && !off)
        else $error("delay left early");
endmodule // ofr_seq
`default_nettype wire

// ==== ofr_host.sv ====
// Purpose: host side of the command port, one transfer at a time
// Assumes: commands are taken on the rising edge with cmd_valid high
// Notes: released lines carry inverted values so nothing stale reads as valid
`timescale 1ns/100ps
`default_nettype none
module ofr_host (
    // clock
    input  wire logic        clk,
    // command port
    output logic             cmd_valid,
    output logic             cmd_write,
    output logic      [7:0]  cmd_code,
    output logic      [15:0] cmd_wdata,
    input  wire logic [15:0] cmd_rdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
    end

    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic [15:0] rd);
        @(posedge clk);
        #2;
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code  = code;
        cmd_wdata = data;
        @(posedge clk);
        #2;
        // read data is registered at the taking edge
        rd        = cmd_rdata;
        cmd_valid = 1'b0;
        cmd_write = ~wr;
        cmd_code  = ~code;
        cmd_wdata = ~data;
    endtask
endmodule // ofr_host
`default_nettype wire

// ==== output_fault_response_control_bench.sv ====
// Purpose: self-checking bench for the fault limit and response block
// Assumes: delay units shortened to 1 us, i.e. 20 clock cycles
// Notes: idle samples sit on the passing side of every limit so only chosen faults fire
`timescale 1ns/100ps
`default_nettype none
module output_fault_response_control_bench;
    import ofr_pkg::*;
    localparam int UNIT = 20;
    logic        clk, nrst, cmd_valid, cmd_write, enable_req, ramping, out_en;
    logic        isense_valid, blank_done, stat_uv, stat_oc, stat_uc, stat_ot;
    logic        stat_otw, stat_temp, alert_n, prev_en;
    logic [7:0]  cmd_code;
    logic [15:0] cmd_wdata, cmd_rdata, strap_vout, vout_meas, i_peak, i_valley;
    logic [15:0] temp_meas, w, d;
    int          fails, checked, seed, rises, cycles;
    int          rtry [4] = '{1, 3, 6, 7};

    ofr_top #(.UV_UNIT_US(1), .OC_UNIT_US(1), .UC_UNIT_US(1), .OT_UNIT_US(1)) DUT (
        .clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .strap_vout(strap_vout), .enable_req(enable_req), .ramping(ramping),
        .out_en(out_en), .vout_meas(vout_meas), .isense_valid(isense_valid),
        .blank_done(blank_done), .i_peak(i_peak), .i_valley(i_valley),
        .temp_meas(temp_meas), .stat_uv(stat_uv), .stat_oc(stat_oc), .stat_uc(stat_uc),
        .stat_ot(stat_ot), .stat_otw(stat_otw), .stat_temp(stat_temp), .alert_n(alert_n));
    ofr_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata));

    function automatic logic [15:0] uv_default(input logic [15:0] s);
        return 16'((32'(s) * UV_NUM) / UV_DEN);
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        host.xfer(1'b1, code, data, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] code, input logic [15:0] exp);
        host.xfer(1'b0, code, 16'h0000, d);
        chk(what, exp, d);
    endtask

    // disabling the rail is the documented way out of a latched fault
    task automatic restart();
        enable_req = 1'b0;
        cyc(2);
        enable_req = 1'b1;
        wr(CMD_CLR, 16'h0000);
    endtask

    task automatic samp(input logic [15:0] pk, input logic [15:0] vl, input logic bl);
        @(posedge clk);
        #2;
        isense_valid = 1'b1;
        i_peak       = pk;
        i_valley     = vl;
        blank_done   = bl;
        @(posedge clk);
        #2;
        isense_valid = 1'b0;
        i_peak       = 16'h0000;
        i_valley     = 16'h0000;
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        prev_en <= out_en;
        if (out_en === 1'b1 && prev_en === 1'b0)
            rises <= rises + 1;
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            fails++;
            summarize();
        end
    end

    initial begin
        fails = 0; checked = 0; rises = 0; cycles = 0; seed = 33605;
        // top of the signed range, so the random limit writes cannot trip undervoltage
        nrst = 1'b0; enable_req = 1'b1; ramping = 1'b0; vout_meas = 16'h7FFF;
        isense_valid = 1'b0; blank_done = 1'b1; i_peak = 16'h0000; i_valley = 16'h0000;
        temp_meas = 16'h8000;
        // kept positive and well clear of zero so a zero sample is under it
        strap_vout = 16'($random(seed)) & 16'h3FFF | 16'h1000;
        repeat (12) @(posedge clk);
        #2;
        nrst = 1'b1;
        cyc(6);
        rdchk("uv limit", CMD_UV_LIM, uv_default(strap_vout));
        rdchk("uv rsp", CMD_UV_RSP, 16'h0080);
        rdchk("ot rsp", CMD_OT_RSP, 16'h0080);
        rdchk("oc limit", CMD_OC_LIM, 16'hE200);
        rdchk("uc limit", CMD_UC_LIM, 16'hE600);
        rdchk("ot limit", CMD_OT_LIM, 16'hEBE8);
        rdchk("otw limit", CMD_OTW_LIM, 16'hEB70);
        rdchk("cfg word", CMD_VCFG, 16'h0001);
        rdchk("unmapped", 8'h77, 16'h0000);
        chk("alert idle", 16'h0001, alert_n);
        repeat (3) begin
            w = 16'($random(seed));
            wr(CMD_UV_LIM, w);
            rdchk("uv limit rw", CMD_UV_LIM, w);
            wr(CMD_UV_RSP, w);
            rdchk("rsp byte", CMD_UV_RSP, {8'h00, w[7:0]});
        end
        wr(CMD_UV_LIM, uv_default(strap_vout));
        wr(CMD_UV_RSP, 16'h0080);
        ramping = 1'b1;
        vout_meas = 16'h0000;
        cyc(5);
        chk("uv ramp", 16'h0000, stat_uv);
        ramping = 1'b0;
        enable_req = 1'b0;
        cyc(5);
        chk("uv disabled", 16'h0000, stat_uv);
        enable_req = 1'b1;
        vout_meas = 16'h0000;
        cyc(3);
        chk("uv off", 16'h0000, out_en);
        chk("uv stat", 16'h0001, stat_uv);
        vout_meas = 16'h7000;
        cyc(3 * UNIT);
        chk("uv latched", 16'h0000, out_en);
        chk("uv sticky", 16'h0001, stat_uv);
        wr(CMD_CLR, 16'h0000);
        chk("uv cleared", 16'h0000, stat_uv);
        chk("alert cleared", 16'h0001, alert_n);
        restart();
        wr(CMD_UV_RSP, 16'h0000);
        vout_meas = 16'h0000;
        cyc(5);
        chk("ignore on", 16'h0001, out_en);
        chk("ignore stat", 16'h0001, stat_uv);
        wr(CMD_UV_RSP, 16'h00C0);
        cyc(3);
        chk("hold off", 16'h0000, out_en);
        vout_meas = 16'h7000;
        cyc(3);
        chk("hold back on", 16'h0001, out_en);
        wr(CMD_UV_RSP, 16'h0042);
        wr(CMD_CLR, 16'h0000);
        vout_meas = 16'h0000;
        cyc(2 * UNIT - 5);
        chk("delay still on", 16'h0001, out_en);
        cyc(UNIT + 15);
        chk("delay then off", 16'h0000, out_en);
        vout_meas = 16'h7000;
        restart();
        foreach (rtry[i]) begin
            wr(CMD_UV_RSP, 16'h0081 | 16'(rtry[i] << 3));
            rises = 0;
            vout_meas = 16'h0000;
            cyc(400);
            vout_meas = 16'h7000;
            if (rtry[i] < 7)
                chk("restarts", 16'(rtry[i]), 16'(rises));
            else
                chk("endless restarts", 16'h0001, 16'(rises > 6));
            restart();
        end
        wr(CMD_OC_LIM, 16'h1000);
        samp(16'h2000, 16'h0000, 1'b0);
        cyc(3);
        chk("oc blanked", 16'h0000, stat_oc);
        samp(16'h2000, 16'h0000, 1'b1);
        cyc(2);
        chk("oc stat", 16'h0001, stat_oc);
        chk("oc off", 16'h0000, out_en);
        rdchk("status word", CMD_STAT, 16'h0082);
        // a passing sample ends the run, else the fault level outlives the clear
        samp(16'h0000, 16'h0000, 1'b1);
        restart();
        wr(CMD_VCFG, 16'h0003);
        samp(16'h2000, 16'h0000, 1'b1);
        samp(16'h2000, 16'h0000, 1'b1);
        samp(16'h0000, 16'h0000, 1'b1);
        samp(16'h2000, 16'h0000, 1'b1);
        samp(16'h2000, 16'h0000, 1'b1);
        cyc(2);
        chk("oc run short", 16'h0000, stat_oc);
        samp(16'h2000, 16'h0000, 1'b1);
        cyc(2);
        chk("oc run full", 16'h0001, stat_oc);
        samp(16'h0000, 16'h0000, 1'b1);
        restart();
        repeat (3) samp(16'h0000, 16'h8000, 1'b1);
        cyc(2);
        chk("uc stat", 16'h0001, stat_uc);
        samp(16'h0000, 16'h0000, 1'b1);
        restart();
        temp_meas = 16'hEBA0;
        cyc(3);
        chk("warn bit", 16'h0001, stat_otw);
        chk("temp bit", 16'h0001, stat_temp);
        chk("warn alert", 16'h0000, alert_n);
        chk("no ot yet", 16'h0000, stat_ot);
        temp_meas = 16'hEBF0;
        cyc(3);
        chk("ot stat", 16'h0001, stat_ot);
        temp_meas = 16'hEBA0;
        wr(CMD_CLR, 16'h0000);
        chk("ot above warn", 16'h0001, stat_ot);
        temp_meas = 16'h8000;
        cyc(2);
        wr(CMD_CLR, 16'h0000);
        chk("ot cleared", 16'h0000, stat_ot);
        chk("alert released", 16'h0001, alert_n);
        summarize();
    end
endmodule // output_fault_response_control_bench
`default_nettype wire
